// [rtl/oltg_pkg.sv]
// shared constants and types for the overtravel limit guard
package oltg_pkg;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STOP_TQ = 8'h04;
    localparam logic [7:0] A_FWD_PUL = 8'h08;
    localparam logic [7:0] A_FWD_TRN = 8'h0C;
    localparam logic [7:0] A_REV_PUL = 8'h10;
    localparam logic [7:0] A_REV_TRN = 8'h14;
    localparam logic [7:0] A_RES = 8'h18;
    localparam logic [7:0] A_HOME = 8'h1C;
    localparam logic [7:0] A_STAT = 8'h20;

    // software overtravel modes
    typedef enum logic [1:0] {
        OLTG_SOFT_OFF = 2'h0,
        OLTG_SOFT_ALARM = 2'h1,
        OLTG_SOFT_STOP = 2'h2
    } oltg_soft_t;

    // control register layout, top field first; fwd_en is bit 0 at the bottom
    typedef struct packed {
        oltg_soft_t soft_mode;
        logic tq_sel;
        logic rev_nc;
        logic fwd_nc;
        logic rev_asg;
        logic fwd_asg;
        logic rev_en;
        logic fwd_en;
    } oltg_cfg_t;

    // status register layout
    typedef struct packed {
        logic over_rev;
        logic over_fwd;
        logic soft_stop;
        logic alarm;
        logic rev_hw;
        logic fwd_hw;
    } oltg_stat_t;

    localparam int unsigned CFG_W = 9;
    localparam int unsigned STAT_W = 6;
    localparam int unsigned ST_ALARM = 2;
    localparam logic [CFG_W-1:0] CFG_RST = 9'h0FF;
    localparam logic [8:0] STOP_TQ_MIN = 9'h001;
    localparam logic [8:0] STOP_TQ_MAX = 9'h12C;
    localparam logic [8:0] STOP_TQ_RST = 9'h064;
    localparam logic [8:0] TQ_FULL = 9'h12C;
    localparam logic [15:0] TURNS_MAX = 16'h7D00;
    localparam logic [15:0] TURNS_RST = 16'h03E8;
    localparam logic [30:0] PULSES_RST = 31'h0000_0000;
    localparam logic [31:0] RES_RST = 32'h0001_0000;
endpackage : oltg_pkg

// [rtl/oltg_sync.sv]
// two-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ns
module oltg_sync #(
    parameter int unsigned W = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    if (W < 1)
    begin : g_bad_w
        $error("oltg_sync: W must be at least 1");
    end

    // one generate lane per pin; first stage feeds only the second
    for (genvar i = 0; i < W; i++)
    begin : g_lane
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                meta_q[i] <= 1'b0;
                q[i] <= 1'b0;
            end
            else
            begin
                meta_q[i] <= d[i];
                q[i] <= meta_q[i];
            end
        end
    end
endmodule : oltg_sync

// [rtl/oltg_guard.sv]
// overtravel limit guard: hardware inhibits, soft range check, ahb regs
//
// Behaviour
// - tripped limit in present direction forces that direction's speed to zero
// - speed away from a tripped limit passes unchanged
// - forward inhibit input forbids forward motion
// - reverse inhibit input forbids reverse motion
// - inhibit enables: 0 ignore, 1 honour, both reset to 1
// - hardware protection needs enable set and terminal assigned
// - inhibit inputs default normally closed, open wire means limit
// - both enables 0 turns hardware protection off
// - unassigned inhibit terminal means hardware protection off
// - inhibit or emergency stop clamps stop torque to 1..300 percent, default 100
// - stop torque clamp is a magnitude, same both directions
// - torque select 0 uses configured stop torque as limit
// - torque select 1, default, makes torque limit zero
// - soft overtravel enabled and position out of window raises alarm
// - travel window measured from home, forward and reverse ranges
// - forward range is pulses plus turns, defaults 0 and 1000
// - reverse range is pulses plus turns, defaults 0 and 1000
// - soft mode: 0 off, 1 alarm, 2 stop no alarm, default 1
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
module oltg_guard
    import oltg_pkg::*;
#(
    parameter int unsigned TURN_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic forward_inhibit_in,
    input wire logic reverse_inhibit_in,
    input wire logic estop_in,
    input wire logic signed [31:0] speed_cmd_in,
    input wire logic signed [15:0] torque_cmd_in,
    input wire logic signed [TURN_W-1:0] enc_turns_in,
    input wire logic [31:0] enc_pulses_in,
    output logic signed [31:0] speed_cmd_out,
    output logic signed [15:0] torque_cmd_out,
    output logic [8:0] torque_limit_out,
    output logic torque_clamp_active,
    output logic soft_overtravel_alarm,
    output logic soft_stop_active
);
    if (TURN_W < 2 || TURN_W > 31)
    begin : g_bad_turn_w
        $error("oltg_guard: TURN_W out of 2..31");
    end

    oltg_cfg_t cfg_q;
    logic [8:0] stop_tq_q;
    logic [30:0] fwd_pul_q, rev_pul_q;
    logic [15:0] fwd_trn_q, rev_trn_q;
    logic [31:0] res_q;
    logic signed [63:0] home_q, pos_q, fwd_lim_q, rev_lim_q;
    logic hw_fwd_q, hw_rev_q, over_fwd_q, over_rev_q, alarm_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [2:0] pin_s;
    logic fwd_act, rev_act, estop_s, stop_act, fwd_blk, rev_blk;
    logic addr_take, wr_now, alarm_clr, soft_stop_d;
    logic [8:0] stop_lim;
    logic [31:0] rd_mux;
    logic [8:0] wr_tq;
    logic [15:0] wr_trn;
    logic signed [63:0] res_x, pos_d, fwd_span, rev_span;
    oltg_stat_t stat;

    // pins come from switches: two flops before anything looks at them
    oltg_sync #(
        .W(3)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({estop_in, reverse_inhibit_in, forward_inhibit_in}),
        .q(pin_s)
    );

    // contact polarity: normally closed reads low as tripped
    assign fwd_act = cfg_q.fwd_nc ? ~pin_s[0] : pin_s[0];
    assign rev_act = cfg_q.rev_nc ? ~pin_s[1] : pin_s[1];
    assign estop_s = pin_s[2];

    // ahb address phase, zero wait states
    assign addr_take = hsel & hready & htrans[1];
    assign wr_now = wr_pend_q;
    assign alarm_clr = wr_now && wr_addr_q == A_STAT && hwdata[ST_ALARM];

    // clamp written values into their legal ranges
    assign wr_tq = (hwdata[31:9] != 23'h0 || hwdata[8:0] > STOP_TQ_MAX) ? STOP_TQ_MAX :
                   (hwdata[8:0] < STOP_TQ_MIN) ? STOP_TQ_MIN : hwdata[8:0];
    assign wr_trn = (hwdata[31:16] != 16'h0 || hwdata[15:0] > TURNS_MAX) ? TURNS_MAX
                    : hwdata[15:0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= addr_take & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // settings written in the data phase, used next cycle without restart
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_q <= oltg_cfg_t'(CFG_RST);
            stop_tq_q <= STOP_TQ_RST;
            fwd_pul_q <= PULSES_RST;
            fwd_trn_q <= TURNS_RST;
            rev_pul_q <= PULSES_RST;
            rev_trn_q <= TURNS_RST;
            res_q <= RES_RST;
        end
        else if (wr_now)
        begin
            unique case (wr_addr_q)
                A_CTRL: cfg_q <= oltg_cfg_t'(hwdata[CFG_W-1:0]);
                A_STOP_TQ: stop_tq_q <= wr_tq;
                A_FWD_PUL: fwd_pul_q <= hwdata[30:0];
                A_FWD_TRN: fwd_trn_q <= wr_trn;
                A_REV_PUL: rev_pul_q <= hwdata[30:0];
                A_REV_TRN: rev_trn_q <= wr_trn;
                A_RES: res_q <= hwdata;
                default: ;
            endcase
        end
    end

    // writing the home register captures the present position as origin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            home_q <= 64'sh0;
        else if (wr_now && wr_addr_q == A_HOME)
            home_q <= pos_q;
    end

    // hardware inhibit: needs enable and assigned terminal
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hw_fwd_q <= 1'b0;
            hw_rev_q <= 1'b0;
        end
        else
        begin
            hw_fwd_q <= cfg_q.fwd_en & cfg_q.fwd_asg & fwd_act;
            hw_rev_q <= cfg_q.rev_en & cfg_q.rev_asg & rev_act;
        end
    end

    // one signed position: turns times resolution plus pulses in turn
    assign res_x = 64'($signed({1'b0, res_q}));
    assign pos_d = 64'(enc_turns_in) * res_x + 64'($signed({1'b0, enc_pulses_in}));
    assign fwd_span = 64'($signed({1'b0, fwd_trn_q})) * res_x
                      + 64'($signed({1'b0, fwd_pul_q}));
    assign rev_span = 64'($signed({1'b0, rev_trn_q})) * res_x
                      + 64'($signed({1'b0, rev_pul_q}));

    // position and window are registered to keep the multipliers off the compare
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pos_q <= 64'sh0;
            fwd_lim_q <= 64'sh0;
            rev_lim_q <= 64'sh0;
        end
        else
        begin
            pos_q <= pos_d;
            fwd_lim_q <= home_q + fwd_span;
            rev_lim_q <= home_q - rev_span;
        end
    end

    // out-of-window flags, quiet while the soft check is off
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            over_fwd_q <= 1'b0;
            over_rev_q <= 1'b0;
        end
        else
        begin
            over_fwd_q <= cfg_q.soft_mode != OLTG_SOFT_OFF && pos_q > fwd_lim_q;
            over_rev_q <= cfg_q.soft_mode != OLTG_SOFT_OFF && pos_q < rev_lim_q;
        end
    end

    // sticky alarm; a new exceed in the clear cycle wins over the clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            alarm_q <= 1'b0;
        else if (cfg_q.soft_mode == OLTG_SOFT_ALARM && (over_fwd_q | over_rev_q))
            alarm_q <= 1'b1;
        else if (alarm_clr)
            alarm_q <= 1'b0;
    end

    // alarm stops both directions; stop mode blocks only the exceeded side
    assign soft_stop_d = cfg_q.soft_mode == OLTG_SOFT_STOP && (over_fwd_q | over_rev_q);
    assign fwd_blk = hw_fwd_q | alarm_q | (cfg_q.soft_mode == OLTG_SOFT_STOP & over_fwd_q);
    assign rev_blk = hw_rev_q | alarm_q | (cfg_q.soft_mode == OLTG_SOFT_STOP & over_rev_q);

    // speed gate: zero toward the limit, pass when backing away
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            speed_cmd_out <= 32'sh0;
        else if ((fwd_blk && speed_cmd_in > 0) || (rev_blk && speed_cmd_in < 0))
            speed_cmd_out <= 32'sh0;
        else
            speed_cmd_out <= speed_cmd_in;
    end

    // stop torque: inhibit or estop engages the clamp
    assign stop_act = hw_fwd_q | hw_rev_q | estop_s;
    assign stop_lim = cfg_q.tq_sel ? 9'h000 : stop_tq_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            torque_limit_out <= TQ_FULL;
            torque_clamp_active <= 1'b0;
            torque_cmd_out <= 16'sh0;
        end
        else
        begin
            torque_limit_out <= stop_act ? stop_lim : TQ_FULL;
            torque_clamp_active <= stop_act;
            // magnitude clamp, symmetric in both rotations
            if (stop_act && torque_cmd_in > $signed({7'h00, stop_lim}))
                torque_cmd_out <= $signed({7'h00, stop_lim});
            else if (stop_act && torque_cmd_in < -$signed({7'h00, stop_lim}))
                torque_cmd_out <= -$signed({7'h00, stop_lim});
            else
                torque_cmd_out <= torque_cmd_in;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            soft_overtravel_alarm <= 1'b0;
            soft_stop_active <= 1'b0;
        end
        else
        begin
            soft_overtravel_alarm <= alarm_q;
            soft_stop_active <= soft_stop_d;
        end
    end

    // read mux; read data is latched in the address phase
    assign stat = '{over_rev: over_rev_q, over_fwd: over_fwd_q, soft_stop: soft_stop_d,
                    alarm: alarm_q, rev_hw: hw_rev_q, fwd_hw: hw_fwd_q};

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            A_CTRL: rd_mux = {23'h0, cfg_q};
            A_STOP_TQ: rd_mux = {23'h0, stop_tq_q};
            A_FWD_PUL: rd_mux = {1'b0, fwd_pul_q};
            A_FWD_TRN: rd_mux = {16'h0, fwd_trn_q};
            A_REV_PUL: rd_mux = {1'b0, rev_pul_q};
            A_REV_TRN: rd_mux = {16'h0, rev_trn_q};
            A_RES: rd_mux = res_q;
            A_HOME: rd_mux = home_q[31:0];
            A_STAT: rd_mux = {26'h0, stat};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // slave never stalls and always answers okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            if (addr_take && !hwrite)
                hrdata <= rd_mux;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_FWD_ZERO: assert property (
        (hw_fwd_q && speed_cmd_in > 0) |=> speed_cmd_out == 0)
        else $error("forward speed not zeroed at limit");
    AST_BACK_AWAY: assert property (
        (hw_fwd_q && !rev_blk && speed_cmd_in < 0) |=> speed_cmd_out == $past(speed_cmd_in))
        else $error("reverse speed blocked by forward limit");
    AST_FWD_PIN: assert property (
        (cfg_q.fwd_en && cfg_q.fwd_asg && !cfg_q.fwd_nc && forward_inhibit_in)[*4]
        |-> hw_fwd_q)
        else $error("forward inhibit pin not honoured");
    AST_REV_NC: assert property (
        (cfg_q.rev_en && cfg_q.rev_asg && cfg_q.rev_nc && !reverse_inhibit_in)[*4]
        |-> hw_rev_q)
        else $error("open reverse contact not seen as limit");
    AST_HW_OFF: assert property (
        (!cfg_q.fwd_en && !cfg_q.rev_en) |=> (!hw_fwd_q && !hw_rev_q))
        else $error("hardware protection active while disabled");
    AST_UNASSIGNED: assert property (
        !cfg_q.fwd_asg |=> !hw_fwd_q)
        else $error("unassigned forward terminal acted");
    AST_STOP_TQ: assert property (
        (stop_act && !cfg_q.tq_sel) |=> torque_limit_out == $past(stop_tq_q))
        else $error("stop torque limit wrong");
    AST_TQ_ZERO: assert property (
        (stop_act && cfg_q.tq_sel) |=> (torque_limit_out == 9'h000 && torque_cmd_out == 0))
        else $error("torque not zero with select set");
    AST_CLAMP_ABS: assert property (
        torque_clamp_active |-> (torque_cmd_out <= $signed({7'h00, torque_limit_out})
        && torque_cmd_out >= -$signed({7'h00, torque_limit_out})))
        else $error("torque outside symmetric clamp");
    AST_ALARM_SET: assert property (
        (cfg_q.soft_mode == OLTG_SOFT_ALARM && over_fwd_q) |=> ##1 soft_overtravel_alarm)
        else $error("soft overtravel alarm missing");
    AST_STOP_NO_ALARM: assert property (
        (cfg_q.soft_mode == OLTG_SOFT_STOP && !alarm_q && !alarm_clr) |=> !alarm_q)
        else $error("alarm raised in stop mode");
    AST_SOFT_OFF: assert property (
        cfg_q.soft_mode == OLTG_SOFT_OFF |=> (!over_fwd_q && !over_rev_q))
        else $error("window flags set while soft check off");

    COV_FWD_TRIP: cover property (hw_fwd_q && speed_cmd_in > 0 ##1 speed_cmd_out == 0);
    COV_ALARM: cover property ($rose(alarm_q));
    COV_SOFT_STOP: cover property ($rose(soft_stop_d));
    COV_ESTOP: cover property (estop_s && !hw_fwd_q && !hw_rev_q);
endmodule : oltg_guard

// [verif/oltg_partner.sv]
// limit switch and encoder model facing the guard's pins
`timescale 1ns/1ns
module oltg_partner (
    input wire logic hclk,
    input wire logic fwd_trip,
    input wire logic rev_trip,
    input wire logic nc_wiring,
    input wire logic open_wire,
    input wire logic signed [15:0] turns,
    input wire logic [31:0] pulses,
    output logic forward_inhibit_in,
    output logic reverse_inhibit_in,
    output logic signed [15:0] enc_turns_in,
    output logic [31:0] enc_pulses_in
);
    // a closed contact opens on trip; a cut wire always reads as open
    assign forward_inhibit_in = open_wire ? 1'b0 : (nc_wiring ? ~fwd_trip : fwd_trip);
    assign reverse_inhibit_in = open_wire ? 1'b0 : (nc_wiring ? ~rev_trip : rev_trip);
    // encoder counter moves on the clock, as the real one does
    always_ff @(posedge hclk)
    begin
        enc_turns_in <= turns;
        enc_pulses_in <= pulses;
    end
endmodule : oltg_partner

// [verif/tb_overtravel_limit_guard.sv]
// self-checking bench for the overtravel limit guard
`timescale 1ns/1ns
module tb_overtravel_limit_guard
    import oltg_pkg::*;
();
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, estop_in;
    logic [31:0] haddr, hwdata, hrdata, enc_pulses;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic fwd_inh, rev_inh, fwd_trip, rev_trip, nc_wiring, open_wire;
    logic signed [31:0] speed_cmd_in, speed_cmd_out;
    logic signed [15:0] torque_cmd_in, torque_cmd_out, enc_turns, turns_pin;
    logic [31:0] pulses_pin;
    logic [8:0] torque_limit_out;
    logic torque_clamp_active, soft_overtravel_alarm, soft_stop_active;
    int n_mismatch = 0;
    int cmp_count = 0;

    // one pin case: pins are {fwd trip, rev trip, nc wiring, open wire}
    typedef struct {
        logic [8:0] ctrl;
        logic [3:0] pins;
        logic es;
        logic signed [31:0] spd;
        logic signed [15:0] tq;
        logic signed [31:0] e_spd;
        logic signed [15:0] e_tq;
        logic [8:0] e_lim;
        logic e_clamp;
    } oltg_row_t;

    // stop torque is 50 percent for all rows
    oltg_row_t rows [14] = '{
        '{9'h0FF, 4'h2, 1'b0, 32'sh3E8, 16'sh50, 32'sh3E8, 16'sh50, 9'h12C, 1'b0},
        '{9'h0FF, 4'hA, 1'b0, 32'sh3E8, 16'sh50, 32'sh0, 16'sh0, 9'h000, 1'b1},
        '{9'h0FF, 4'hA, 1'b0, -32'sh3E8, 16'sh50, -32'sh3E8, 16'sh0, 9'h000, 1'b1},
        '{9'h0FF, 4'h6, 1'b0, -32'sh3E8, 16'sh50, 32'sh0, 16'sh0, 9'h000, 1'b1},
        '{9'h0FF, 4'h6, 1'b0, 32'sh3E8, 16'sh50, 32'sh3E8, 16'sh0, 9'h000, 1'b1},
        '{9'h0BF, 4'hA, 1'b0, 32'sh3E8, 16'sh50, 32'sh0, 16'sh32, 9'h032, 1'b1},
        '{9'h0BF, 4'h6, 1'b0, 32'sh3E8, -16'sh50, 32'sh3E8, -16'sh32, 9'h032, 1'b1},
        '{9'h0FC, 4'hE, 1'b0, 32'sh3E8, 16'sh50, 32'sh3E8, 16'sh50, 9'h12C, 1'b0},
        '{9'h0F3, 4'hE, 1'b0, 32'sh3E8, 16'sh50, 32'sh3E8, 16'sh50, 9'h12C, 1'b0},
        '{9'h0FE, 4'hA, 1'b0, 32'sh3E8, 16'sh50, 32'sh3E8, 16'sh50, 9'h12C, 1'b0},
        '{9'h0CF, 4'h8, 1'b0, 32'sh3E8, 16'sh50, 32'sh0, 16'sh0, 9'h000, 1'b1},
        '{9'h0FF, 4'h3, 1'b0, 32'sh3E8, 16'sh50, 32'sh0, 16'sh0, 9'h000, 1'b1},
        '{9'h0FF, 4'h2, 1'b1, 32'sh3E8, 16'sh50, 32'sh3E8, 16'sh0, 9'h000, 1'b1},
        '{9'h0BF, 4'h2, 1'b1, -32'sh3E8, -16'sh50, -32'sh3E8, -16'sh32, 9'h032, 1'b1}
    };
    // register reset values: address above, value below
    logic [39:0] rst_regs [7] = '{{A_CTRL, 32'h0FF}, {A_STOP_TQ, 32'h64}, {A_FWD_PUL, 32'h0},
        {A_FWD_TRN, 32'h3E8}, {A_REV_PUL, 32'h0}, {A_REV_TRN, 32'h3E8}, {A_RES, 32'h10000}};

    oltg_guard #(.TURN_W(16)) u_oltg_guard (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .forward_inhibit_in(fwd_inh), .reverse_inhibit_in(rev_inh), .estop_in(estop_in),
        .speed_cmd_in(speed_cmd_in), .torque_cmd_in(torque_cmd_in), .enc_turns_in(turns_pin),
        .enc_pulses_in(pulses_pin), .speed_cmd_out(speed_cmd_out),
        .torque_cmd_out(torque_cmd_out), .torque_limit_out(torque_limit_out),
        .torque_clamp_active(torque_clamp_active),
        .soft_overtravel_alarm(soft_overtravel_alarm), .soft_stop_active(soft_stop_active));

    oltg_partner u_oltg_partner (.hclk(hclk), .fwd_trip(fwd_trip), .rev_trip(rev_trip),
        .nc_wiring(nc_wiring), .open_wire(open_wire), .turns(enc_turns), .pulses(enc_pulses),
        .forward_inhibit_in(fwd_inh), .reverse_inhibit_in(rev_inh),
        .enc_turns_in(turns_pin), .enc_pulses_in(pulses_pin));

    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // no fixed wait count: the watchdog ends a slave that never answers
    task automatic wait_rdy;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb(1'b1, a, d, unused);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0, v);
        chk(v, e);
        chk({30'h0, hreadyout, hresp}, 32'h2);
    endtask : rd_chk

    // move the encoder, let the compare pipeline settle, check flags
    task automatic enc(input logic signed [15:0] t, input logic [31:0] p, input logic ea,
        input logic es);
        @(posedge hclk);
        enc_turns <= t;
        enc_pulses <= p;
        repeat (8) @(posedge hclk);
        chk(soft_overtravel_alarm, ea);
        chk(soft_stop_active, es);
    endtask : enc

    initial
    begin
        #400000;
        n_mismatch++;
        finish_test;
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        estop_in = 1'b0;
        {fwd_trip, rev_trip, nc_wiring, open_wire} = 4'h2;
        speed_cmd_in = 32'sh0;
        torque_cmd_in = 16'sh0;
        enc_turns = 16'sh0;
        enc_pulses = 32'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        wr(A_STOP_TQ, 32'h32);
        // pin cases: config change takes effect with no re-enable
        foreach (rows[i])
        begin
            wr(A_CTRL, {23'h0, rows[i].ctrl});
            @(posedge hclk);
            {fwd_trip, rev_trip, nc_wiring, open_wire} <= rows[i].pins;
            estop_in <= rows[i].es;
            speed_cmd_in <= rows[i].spd;
            torque_cmd_in <= rows[i].tq;
            repeat (8) @(posedge hclk);
            chk(speed_cmd_out, rows[i].e_spd);
            chk(torque_cmd_out, rows[i].e_tq);
            chk(torque_limit_out, rows[i].e_lim);
            chk(torque_clamp_active, rows[i].e_clamp);
        end
        // out-of-range writes clamp; unmapped place reads zero
        wr(A_STOP_TQ, 32'h0);
        rd_chk(A_STOP_TQ, 32'h1);
        wr(A_STOP_TQ, 32'h1FF);
        rd_chk(A_STOP_TQ, 32'h12C);
        wr(A_FWD_TRN, 32'h7D01);
        rd_chk(A_FWD_TRN, 32'h7D00);
        wr(8'h24, 32'hFFFF_FFFF);
        rd_chk(8'h24, 32'h0);
        // soft window: home at +16, forward 2 turns 3 pulses, reverse 1 turn
        @(posedge hclk);
        estop_in <= 1'b0;
        {fwd_trip, rev_trip, nc_wiring, open_wire} <= 4'h2;
        speed_cmd_in <= 32'sh3E8;
        wr(A_CTRL, 32'h0FF);
        wr(A_RES, 32'h10);
        enc(16'sh1, 32'h0, 1'b0, 1'b0);
        wr(A_HOME, 32'h0);
        rd_chk(A_HOME, 32'h10);
        wr(A_FWD_PUL, 32'h3);
        wr(A_FWD_TRN, 32'h2);
        wr(A_REV_PUL, 32'h0);
        wr(A_REV_TRN, 32'h1);
        enc(16'sh3, 32'h3, 1'b0, 1'b0);
        enc(16'sh3, 32'h4, 1'b1, 1'b0);
        chk(speed_cmd_out, 32'h0);
        enc(16'sh0, 32'h0, 1'b1, 1'b0);
        wr(A_STAT, 32'h4);
        enc(16'sh0, 32'h0, 1'b0, 1'b0);
        enc(-16'sh1, 32'hF, 1'b1, 1'b0);
        enc(16'sh0, 32'h0, 1'b1, 1'b0);
        wr(A_STAT, 32'h4);
        // stop mode blocks only the exceeded side and raises no alarm
        wr(A_CTRL, 32'h17F);
        enc(16'sh3, 32'h4, 1'b0, 1'b1);
        chk(speed_cmd_out, 32'h0);
        rd_chk(A_STAT, 32'h18);
        speed_cmd_in <= -32'sh3E8;
        repeat (4) @(posedge hclk);
        chk(speed_cmd_out, -32'sh3E8);
        wr(A_CTRL, 32'h07F);
        enc(16'sh3, 32'h4, 1'b0, 1'b0);
        // second reset in mid-run, then register defaults
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        chk(speed_cmd_out, 32'h0);
        chk(torque_limit_out, 32'h12C);
        chk(soft_overtravel_alarm, 1'b0);
        hresetn <= 1'b1;
        foreach (rst_regs[i])
            rd_chk(rst_regs[i][39:32], rst_regs[i][31:0]);
        finish_test;
    end
endmodule : tb_overtravel_limit_guard
